// ---- logic/gpij_defs.vh ----
// Register offsets, field layouts and reset values of the two 8-bit ports
`ifndef GPIJ_DEFS_VH
`define GPIJ_DEFS_VH
`define GPIJ_OFS_DATA 6'h00
`define GPIJ_OFS_OUTEN 6'h04
`define GPIJ_OFS_FUNC 6'h08
`define GPIJ_OFS_RSVD 6'h10
`define GPIJ_OFS_PULLUP 6'h2C
`define GPIJ_OFS_INEN 6'h38
`define GPIJ_SEL_PORT_I 1'b0
`define GPIJ_SEL_PORT_J 1'b1
`define GPIJ_PORT_SEL_BIT 6
`define GPIJ_ADDR_W 7
`define GPIJ_PORT_W 8
`define GPIJ_RST_BYTE 8'h00
`define GPIJ_ZERO_HI 24'h000000
`define GPIJ_SLVERR_RSVD 1'b1
`endif

// ---- logic/gpij_ports.v ----
// Two 8-bit general-purpose I/O ports with APB register access
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "gpij_defs.vh"
// Summary of operation
// - Port J has eight pins, each input or output, direction set per bit.
// - Port J input and output are enabled by separate per-bit enable bits.
// - Port J function bits route timer 6/7 outputs and interrupt inputs to pins.
// - After reset all port J bits are port pins with input, output, pull-up off.
// - Interrupt input with function and input enable stays live in STOP, drive off.
// - Outside STOP, any input-enabled port J pin 0-3, 6 or 7 feeds interrupt logic regardless.
// - Port J data register holds bits 7-0, upper bits read zero, reset zero.
// - Port J output control bits 7-0, 1 enables the driver, reset zero.
// - Port J data at 0x00, output control at 0x04, function at 0x08.
// - Port J pull-up control at 0x2C, input control at 0x38.
// - Port I output control gives per-pin driver enables in bits 7-0.
// - Port I function 1 selects timer-4 captures on bits 7,6 and timer outputs below.
// - Port I pull-up control enables pull-ups per bit, reset zero.
// - Port I input control enables input buffers per bit, reset zero.
// - Port I registers use the same offsets within their own base.
module gpij_ports (
    input wire I_CLK,
    input wire I_RST,
    input wire I_PSEL,
    input wire I_PENABLE,
    input wire I_PWRITE,
    input wire [6:0] I_PADDR,
    input wire [31:0] I_PWDATA,
    output reg [31:0] O_PRDATA,
    output reg O_PREADY,
    output reg O_PSLVERR,
    input wire [7:0] I_PI_PIN,
    output reg [7:0] O_PI_PIN,
    output reg [7:0] O_PI_PIN_OE,
    output reg [7:0] O_PI_PULLUP,
    input wire [7:0] I_PJ_PIN,
    output reg [7:0] O_PJ_PIN,
    output reg [7:0] O_PJ_PIN_OE,
    output reg [7:0] O_PJ_PULLUP,
    input wire [5:0] I_TIMER_OUT_I,
    input wire [1:0] I_TIMER_OUT_J,
    output reg O_TIMER4_CAPTURE_INPUT_A,
    output reg O_TIMER4_CAPTURE_INPUT_B,
    input wire I_STOP_MODE,
    input wire I_STANDBY_PIN_DRIVE_CONTROL,
    output reg [5:0] O_EXT_INT
);

    reg [7:0] pi_data_reg;
    reg [7:0] pi_outen_reg;
    reg [7:0] pi_func_reg;
    reg [7:0] pi_pullup_reg;
    reg [7:0] pi_inen_reg;
    reg [7:0] pj_data_reg;
    reg [7:0] pj_outen_reg;
    reg [7:0] pj_func_reg;
    reg [7:0] pj_pullup_reg;
    reg [7:0] pj_inen_reg;
    wire [7:0] pi_out_next;
    wire [7:0] pj_out_next;
    reg [7:0] rd_byte_next;
    reg rd_hit_next;
    reg [5:0] ext_int_next;
    reg [7:0] pj_int_live;
    wire [7:0] pi_in_gated;
    wire [7:0] pj_in_gated;
    wire [7:0] pj_oe_eff;
    wire [7:0] pi_oe_eff;
    wire [7:0] pi_pu_eff;
    wire [7:0] pj_pu_eff;
    wire [5:0] ofs;
    wire sel_j;
    wire setup_ph;
    wire wr_en;
    wire stop_drive_off;
    genvar g;

    // Offset match, shared by write decode and read mux
    function is_ofs;
        input [5:0] a;
        input [5:0] o;
        begin
            is_ofs = (a == o);
        end
    endfunction

    assign ofs = I_PADDR[5:0];
    assign sel_j = I_PADDR[`GPIJ_PORT_SEL_BIT];
    assign setup_ph = I_PSEL & ~I_PENABLE;
    assign wr_en = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE;
    assign stop_drive_off = I_STOP_MODE & I_STANDBY_PIN_DRIVE_CONTROL;

    // Input buffers gate pins to zero when disabled
    assign pi_in_gated = I_PI_PIN & pi_inen_reg;
    assign pj_in_gated = I_PJ_PIN & pj_inen_reg;
    // Standby drive control releases pins in STOP
    assign pi_oe_eff = stop_drive_off ? `GPIJ_RST_BYTE : pi_outen_reg;
    assign pj_oe_eff = stop_drive_off ? `GPIJ_RST_BYTE : pj_outen_reg;
    assign pi_pu_eff = stop_drive_off ? `GPIJ_RST_BYTE : pi_pullup_reg;
    assign pj_pu_eff = stop_drive_off ? `GPIJ_RST_BYTE : pj_pullup_reg;

    // Output mux: port data or timer output per function bit
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_out
            if (g < 6) begin : g_pi_tmr
                assign pi_out_next[g] = pi_func_reg[g] ? I_TIMER_OUT_I[g] : pi_data_reg[g];
            end else begin : g_pi_port
                assign pi_out_next[g] = pi_data_reg[g];
            end
            if (g == 4 || g == 5) begin : g_pj_tmr
                assign pj_out_next[g] = pj_func_reg[g] ? I_TIMER_OUT_J[g-4] : pj_data_reg[g];
            end else begin : g_pj_port
                assign pj_out_next[g] = pj_data_reg[g];
            end
        end
    endgenerate

    // Interrupt path of port J pins 0-3, 6, 7
    always @* begin
        if (I_STOP_MODE) begin
            pj_int_live = pj_in_gated & pj_func_reg;
        end else begin
            pj_int_live = pj_in_gated;
        end
        ext_int_next = {pj_int_live[7:6], pj_int_live[3:0]};
    end

    // Read mux; reserved and unmapped offsets answer zero with error
    always @* begin
        rd_byte_next = `GPIJ_RST_BYTE;
        rd_hit_next = 1'b1;
        if (is_ofs(ofs, `GPIJ_OFS_DATA)) begin
            rd_byte_next = sel_j ? ((pj_data_reg & pj_outen_reg) | (pj_in_gated & ~pj_outen_reg))
                                 : ((pi_data_reg & pi_outen_reg) | (pi_in_gated & ~pi_outen_reg));
        end else if (is_ofs(ofs, `GPIJ_OFS_OUTEN)) begin
            rd_byte_next = sel_j ? pj_outen_reg : pi_outen_reg;
        end else if (is_ofs(ofs, `GPIJ_OFS_FUNC)) begin
            rd_byte_next = sel_j ? pj_func_reg : pi_func_reg;
        end else if (is_ofs(ofs, `GPIJ_OFS_PULLUP)) begin
            rd_byte_next = sel_j ? pj_pullup_reg : pi_pullup_reg;
        end else if (is_ofs(ofs, `GPIJ_OFS_INEN)) begin
            rd_byte_next = sel_j ? pj_inen_reg : pi_inen_reg;
        end else begin
            rd_hit_next = 1'b0;
        end
    end

    // Register file; only byte 0 of the write data is stored
    always @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            pi_data_reg <= `GPIJ_RST_BYTE;
            pi_outen_reg <= `GPIJ_RST_BYTE;
            pi_func_reg <= `GPIJ_RST_BYTE;
            pi_pullup_reg <= `GPIJ_RST_BYTE;
            pi_inen_reg <= `GPIJ_RST_BYTE;
            pj_data_reg <= `GPIJ_RST_BYTE;
            pj_outen_reg <= `GPIJ_RST_BYTE;
            pj_func_reg <= `GPIJ_RST_BYTE;
            pj_pullup_reg <= `GPIJ_RST_BYTE;
            pj_inen_reg <= `GPIJ_RST_BYTE;
        end else if (wr_en) begin
            if (sel_j == `GPIJ_SEL_PORT_J) begin
                if (is_ofs(ofs, `GPIJ_OFS_DATA)) pj_data_reg <= I_PWDATA[7:0];
                if (is_ofs(ofs, `GPIJ_OFS_OUTEN)) pj_outen_reg <= I_PWDATA[7:0];
                if (is_ofs(ofs, `GPIJ_OFS_FUNC)) pj_func_reg <= I_PWDATA[7:0];
                if (is_ofs(ofs, `GPIJ_OFS_PULLUP)) pj_pullup_reg <= I_PWDATA[7:0];
                if (is_ofs(ofs, `GPIJ_OFS_INEN)) pj_inen_reg <= I_PWDATA[7:0];
            end else begin
                if (is_ofs(ofs, `GPIJ_OFS_DATA)) pi_data_reg <= I_PWDATA[7:0];
                if (is_ofs(ofs, `GPIJ_OFS_OUTEN)) pi_outen_reg <= I_PWDATA[7:0];
                if (is_ofs(ofs, `GPIJ_OFS_FUNC)) pi_func_reg <= I_PWDATA[7:0];
                if (is_ofs(ofs, `GPIJ_OFS_PULLUP)) pi_pullup_reg <= I_PWDATA[7:0];
                if (is_ofs(ofs, `GPIJ_OFS_INEN)) pi_inen_reg <= I_PWDATA[7:0];
            end
        end
    end

    // APB answer: no wait state, data and error registered in setup
    always @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_PREADY <= 1'b0;
            O_PRDATA <= 32'h00000000;
            O_PSLVERR <= 1'b0;
        end else if (setup_ph) begin
            O_PREADY <= 1'b1;
            O_PRDATA <= I_PWRITE ? 32'h00000000 : {`GPIJ_ZERO_HI, rd_byte_next};
            O_PSLVERR <= ~rd_hit_next & `GPIJ_SLVERR_RSVD;
        end else begin
            O_PREADY <= 1'b0;
            O_PRDATA <= 32'h00000000;
            O_PSLVERR <= 1'b0;
        end
    end

    // Pin and peripheral outputs, all registered
    always @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_PI_PIN <= `GPIJ_RST_BYTE;
            O_PI_PIN_OE <= `GPIJ_RST_BYTE;
            O_PI_PULLUP <= `GPIJ_RST_BYTE;
            O_PJ_PIN <= `GPIJ_RST_BYTE;
            O_PJ_PIN_OE <= `GPIJ_RST_BYTE;
            O_PJ_PULLUP <= `GPIJ_RST_BYTE;
            O_TIMER4_CAPTURE_INPUT_A <= 1'b0;
            O_TIMER4_CAPTURE_INPUT_B <= 1'b0;
            O_EXT_INT <= 6'h00;
        end else begin
            O_PI_PIN <= pi_out_next;
            O_PI_PIN_OE <= pi_oe_eff;
            O_PI_PULLUP <= pi_pu_eff;
            O_PJ_PIN <= pj_out_next;
            O_PJ_PIN_OE <= pj_oe_eff;
            O_PJ_PULLUP <= pj_pu_eff;
            O_TIMER4_CAPTURE_INPUT_A <= pi_in_gated[6] & pi_func_reg[6];
            O_TIMER4_CAPTURE_INPUT_B <= pi_in_gated[7] & pi_func_reg[7];
            O_EXT_INT <= ext_int_next;
        end
    end

endmodule // gpij_ports
`default_nettype wire

// ---- test/gpij_ports_asserts.sv ----
// Checker of bus handshake and reset state of the port J output enables
`timescale 1ns/1ps
`default_nettype none
module gpij_ports_chk (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic [6:0] I_PADDR,
    input wire logic O_PREADY,
    input wire logic O_PSLVERR,
    input wire logic [7:0] O_PJ_PIN_OE
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    wire setup = I_PSEL && !I_PENABLE;
    ready_after_setup_a: assert property (setup |=> O_PREADY) else $error("no ready");
    ready_single_a: assert property (O_PREADY |=> !O_PREADY) else $error("ready held");
    ready_idle_a: assert property (!I_PSEL |=> !O_PREADY) else $error("stray ready");
    err_with_ready_a: assert property (O_PSLVERR |-> O_PREADY) else $error("lone error");
    reserved_err_a: assert property (setup && I_PADDR[5:0] == 6'h10 |=> O_PSLVERR)
        else $error("no error");
    data_map_a: assert property (setup && I_PADDR[5:0] == 6'h00 |=> !O_PSLVERR)
        else $error("data refused");
    input_map_a: assert property (setup && I_PADDR[5:0] == 6'h38 |=> !O_PSLVERR)
        else $error("input refused");
    reset_off_a: assert property ($past(I_RST) |-> O_PJ_PIN_OE == 8'h00) else $error("oe");
    cover property (O_PREADY && O_PSLVERR);
    cover property (setup && I_PADDR[6]);
    cover property (O_PJ_PIN_OE == 8'h0F);
endmodule // gpij_ports_chk
bind gpij_ports gpij_ports_chk u_chk (.I_CLK(I_CLK), .I_RST(I_RST), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PADDR(I_PADDR), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .O_PJ_PIN_OE(O_PJ_PIN_OE));
`default_nettype wire

// ---- test/gpij_pins.sv ----
// Pin-level model of one 8-bit port and its board
`timescale 1ns/1ps
`default_nettype none
module gpij_pins (
    input wire logic [7:0] i_out,
    input wire logic [7:0] i_oe,
    input wire logic [7:0] i_pullup,
    output logic [7:0] o_level
);
    // Released bits go to the pull-up, else away from the last driven value
    assign o_level = (i_oe & i_out) | (~i_oe & (i_pullup | ~i_out));
endmodule // gpij_pins
`default_nettype wire

// ---- test/gpij_ports_tb.sv ----
// Self-checking bench of the two-port block
`timescale 1ns/1ps
`default_nettype none
module gpij_ports_tb;
    logic clk = 1'b0, rst, psel, pen, pwr, prdy, perr, e, capa, capb, stop, drv;
    logic [6:0] pa;
    logic [31:0] pwd, prd, q;
    logic [7:0] pi, po, poe, ppu, ji, jo, joe, jpu;
    logic [5:0] tmi, xint;
    logic [1:0] tmj;
    logic [5:0] ofs [5] = '{6'h00, 6'h04, 6'h08, 6'h2C, 6'h38};
    int mismatches = 0, num_checks = 0;
    gpij_ports dut (.I_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
        .I_PADDR(pa), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(prdy), .O_PSLVERR(perr),
        .I_PI_PIN(pi), .O_PI_PIN(po), .O_PI_PIN_OE(poe), .O_PI_PULLUP(ppu), .I_PJ_PIN(ji),
        .O_PJ_PIN(jo), .O_PJ_PIN_OE(joe), .O_PJ_PULLUP(jpu), .I_TIMER_OUT_I(tmi),
        .I_TIMER_OUT_J(tmj), .O_TIMER4_CAPTURE_INPUT_A(capa), .O_TIMER4_CAPTURE_INPUT_B(capb),
        .I_STOP_MODE(stop), .I_STANDBY_PIN_DRIVE_CONTROL(drv), .O_EXT_INT(xint));
    gpij_pins pin_i (.i_out(po), .i_oe(poe), .i_pullup(ppu), .o_level(pi));
    gpij_pins pin_j (.i_out(jo), .i_oe(joe), .i_pullup(jpu), .o_level(ji));
    initial forever #20 clk = ~clk;
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        num_checks++;
        if (s !== x) begin
            mismatches++;
            $display("Error at %0t seen %h expected %h", $time, s, x);
        end
    endtask
    task automatic apb(input logic w, input logic [6:0] a, input logic [31:0] d, x);
        @(posedge clk);
        {psel, pen, pwr, pa, pwd} <= {2'h2, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (prdy !== 1'b1);
        {e, q} = {perr, prd};
        {psel, pen} <= 2'h0;
        @(posedge clk);
        @(negedge clk);
        if (!w) chk(q, x);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic t_regs;
        chk({poe, ppu, joe, jpu}, 32'h0);
        foreach (ofs[i]) begin
            apb(1'b0, {1'b1, ofs[i]}, 32'h0, 32'h0);
            apb(1'b0, {1'b0, ofs[i]}, 32'h0, 32'h0);
            apb(1'b1, {1'b0, ofs[i]}, 32'hFFFFFF5A, 32'h0);
            apb(1'b0, {1'b0, ofs[i]}, 32'h0, i ? 32'h5A : 32'h0);
        end
        apb(1'b1, 7'h50, 32'h0, 32'h0);
        chk({31'h0, e}, 32'h1);
    endtask
    task automatic t_pj;
        apb(1'b1, 7'h44, 32'hFFFFFF0F, 32'h0);
        apb(1'b1, 7'h40, 32'h05, 32'h0);
        apb(1'b1, 7'h6C, 32'hF0, 32'h0);
        apb(1'b1, 7'h78, 32'hFF, 32'h0);
        chk({24'h0, joe}, 32'h0F);
        apb(1'b0, 7'h40, 32'h0, 32'hF5);
        apb(1'b1, 7'h6C, 32'hFF, 32'h0);
        apb(1'b1, 7'h44, 32'h0, 32'h0);
        apb(1'b0, 7'h78, 32'h0, 32'hFF);
        chk({26'h0, xint}, 32'h3F);
        @(posedge clk) {stop, drv} <= 2'h3;
        apb(1'b1, 7'h48, 32'h0F, 32'h0);
        chk({18'h0, xint, joe | jpu}, 32'h0A00);
        @(posedge clk) {stop, drv} <= 2'h0;
    endtask
    task automatic t_rst;
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk({poe, ppu, joe, jpu}, 32'h0);
        apb(1'b0, 7'h44, 32'h0, 32'h0);
        apb(1'b0, 7'h08, 32'h0, 32'h0);
    endtask
    task automatic t_tmr;
        @(posedge clk) {tmi, tmj} <= 8'hAA;
        apb(1'b1, 7'h04, 32'h0, 32'h0);
        apb(1'b1, 7'h2C, 32'hFF, 32'h0);
        apb(1'b1, 7'h08, 32'hFF, 32'h0);
        apb(1'b1, 7'h38, 32'hC0, 32'h0);
        apb(1'b1, 7'h48, 32'h30, 32'h0);
        chk({22'h0, capb, capa, jo[5:4], po[5:0]}, 32'h3AA);
    endtask
    initial begin
        rst = 1'b1;
        {psel, pen, pwr, stop, drv, pa, pwd, tmi, tmj} = 52'h0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_pj();
        t_tmr();
        t_rst();
        give_verdict();
    end
    initial begin
        #40000;
        mismatches++;
        give_verdict();
    end
endmodule // gpij_ports_tb
`default_nettype wire
